// file: ddrt_pkg.sv
// Purpose: Shared constants, command codes and helpers for the DDR2
//          command timing block.
// Assumes: Commands are sampled on rising edges of the memory clock.
// Notes:   Cycle counts derive from picosecond figures by rounding up.
package ddrt_pkg;

    // Command code {cs_n, ras_n, cas_n, we_n} as sampled on the pins.
    typedef enum logic [3:0] {
        DDRT_CMD_MRS = 4'h0,
        DDRT_CMD_PRE = 4'h2,
        DDRT_CMD_ACT = 4'h3
    } ddrt_cmd_t;

    // Bank address values that select the mode register targets.
    localparam logic [2:0] DDRT_BA_MR = 3'h0;
    localparam logic [2:0] DDRT_BA_EMR = 3'h1;

    // Field positions inside the mode register address word.
    localparam int DDRT_EMR_DQS_BIT = 10;
    localparam int DDRT_MR_PDX_BIT = 12;
    localparam int DDRT_ADDR_W = 14;

    // Registration counts in whole memory clock edges; counter width in bits.
    localparam int DDRT_ODT_DELAY = 2;
    localparam int DDRT_CKE_MIN = 3;
    localparam int DDRT_CNT_W = 8;

    // Reset values: strobe pair differential, fast power-down exit.
    localparam logic DDRT_DQS_DIFF_RST = 1'b1;
    localparam logic DDRT_PDX_SLOW_RST = 1'b0;

    // Round-up division used to turn a minimum time into cycles.
    function automatic int ddrt_ru_div(input int num, input int den);
        ddrt_ru_div = (num + den - 1) / den;
    endfunction

endpackage

// file: ddrt_xing_if.sv
// Purpose: Carries level bits from the memory clock side to the system
//          clock side of the timing block.
// Assumes: Every bit is a level or a toggle, never a multi-bit word.
// Notes:   The receiver holds the synchroniser flip-flops.
`timescale 1ns/1ps
interface ddrt_xing_if #(parameter int WIDTH = 5);
    logic [WIDTH-1:0] src;
    logic [WIDTH-1:0] dst;

    modport drive (output src, input dst);
    modport sync (input src, output dst);
endinterface

// file: ddrt_sync.sv
// Purpose: Two flip-flop synchroniser for independent level bits.
// Assumes: Each bit of the source changes at most once per few cycles.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module ddrt_sync
    import ddrt_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    ddrt_xing_if.sync xing
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } ddrt_sync_st_t;

    ddrt_sync_st_t st_reg;
    ddrt_sync_st_t st_next;

    // Shift the bits through two stages; reset clears both stages.
    always_comb begin
        st_next = st_reg;
        st_next.s1 = xing.src;
        st_next.s2 = st_reg.s1;
        if (!reset_n) begin
            st_next = '0;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign xing.dst = st_reg.s2;

endmodule

// file: ddrt_timing.sv
// Purpose: Device-side command timing of a DDR2 memory: termination
//          switching, mode bits and checks on command spacing.
// Assumes: ck is the memory input clock; clk is the system clock.
// Notes:   Errors cross to clk as toggles and emerge as pulses.
//
// Contract
// - Termination turns on two edges after ODT is first registered high.
// - Termination off half a period after second falling edge past ODT low.
// - Nanosecond minimums become cycles: divide by tCK, round up.
// - Extended mode bit 10 at zero selects the differential strobe pair.
// - Mode bit 12 selects fast or slow active power-down exit timing.
`timescale 1ns/1ps
module ddrt_timing
    import ddrt_pkg::*;
#(
    parameter int TCK_AVG_PS = 80000,
    parameter int TRP_PS = 13125
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ck,
    input wire logic cke,
    input wire logic odt,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [DDRT_ADDR_W-1:0] addr,
    output logic odt_term,
    output logic dqs_diff_mode,
    output logic slow_pd_exit,
    output logic cke_err,
    output logic rp_err
);

    // Precharge to activate spacing in cycles, rounded up, at least one.
    localparam int TNRP_RAW = ddrt_ru_div(TRP_PS, TCK_AVG_PS);
    localparam int TNRP_I = (TNRP_RAW < 1) ? 1 : TNRP_RAW;
    localparam logic [DDRT_CNT_W-1:0] TNRP = TNRP_I[DDRT_CNT_W-1:0];
    localparam logic [DDRT_CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [1:0] CKE_MIN = 2'(DDRT_CKE_MIN);
    localparam logic [1:0] CKE_ONE = 2'h1;
    localparam int XW = 4;

    // Memory clock side state.
    typedef struct packed {
        logic rs1;
        logic rs2;
        logic [DDRT_ODT_DELAY-1:0] odt_sh;
        logic term;
        logic cke_q;
        logic [1:0] cke_cnt;
        logic cke_tgl;
        logic [DDRT_CNT_W-1:0] rp_cnt;
        logic rp_tgl;
        logic dqs_diff;
        logic pdx_slow;
    } ddrt_lnk_st_t;

    // System clock side state.
    typedef struct packed {
        logic cke_tgl_q;
        logic rp_tgl_q;
        logic cke_err;
        logic rp_err;
        logic dqs_diff;
        logic pdx_slow;
    } ddrt_sys_st_t;

    ddrt_lnk_st_t lnk_reg;
    ddrt_lnk_st_t lnk_next;
    ddrt_sys_st_t sys_reg;
    ddrt_sys_st_t sys_next;
    ddrt_cmd_t cmd;
    logic ck_rst_n;
    logic is_mrs_mr;
    logic is_mrs_emr;
    logic is_pre;
    logic is_act;
    logic cke_change;

    ddrt_xing_if #(.WIDTH(XW)) xing ();

    // Command match; a deselected device decodes nothing.
    function automatic logic cmd_is(input logic [3:0] pins,
                                    input ddrt_cmd_t code);
        cmd_is = (pins == code);
    endfunction

    assign cmd = ddrt_cmd_t'({cs_n, ras_n, cas_n, we_n});
    assign is_mrs_mr = cmd_is(cmd, DDRT_CMD_MRS) && (ba == DDRT_BA_MR);
    assign is_mrs_emr = cmd_is(cmd, DDRT_CMD_MRS) && (ba == DDRT_BA_EMR);
    assign is_pre = cmd_is(cmd, DDRT_CMD_PRE);
    assign is_act = cmd_is(cmd, DDRT_CMD_ACT);
    assign cke_change = (cke != lnk_reg.cke_q);
    assign ck_rst_n = lnk_reg.rs2;

    // Memory clock side. ODT shifts through the delay line; the output
    // stage lands on the second edge after the one that registered it.
    // The trailing half period of the off case also ends at that edge.
    always_comb begin
        lnk_next = lnk_reg;
        lnk_next.rs1 = reset_n;
        lnk_next.rs2 = lnk_reg.rs1;
        lnk_next.odt_sh = {lnk_reg.odt_sh[DDRT_ODT_DELAY-2:0], odt};
        lnk_next.term = lnk_reg.odt_sh[DDRT_ODT_DELAY-1];
        lnk_next.cke_q = cke;
        // Count edges that registered the present CKE level.
        if (cke_change) begin
            lnk_next.cke_cnt = CKE_ONE;
            if (lnk_reg.cke_cnt < CKE_MIN) begin
                lnk_next.cke_tgl = ~lnk_reg.cke_tgl;
            end
        end else if (lnk_reg.cke_cnt < CKE_MIN) begin
            lnk_next.cke_cnt = lnk_reg.cke_cnt + CKE_ONE;
        end
        // Precharge spacing down-counter; activate is flagged till zero.
        if (lnk_reg.rp_cnt != '0) begin
            lnk_next.rp_cnt = lnk_reg.rp_cnt - CNT_ONE;
        end
        if (is_act && lnk_reg.rp_cnt != '0) begin
            lnk_next.rp_tgl = ~lnk_reg.rp_tgl;
        end
        if (is_pre) begin
            lnk_next.rp_cnt = TNRP - CNT_ONE;
        end
        // Mode register writes steer strobe mode and exit timing.
        if (is_mrs_emr) begin
            lnk_next.dqs_diff = ~addr[DDRT_EMR_DQS_BIT];
        end
        if (is_mrs_mr) begin
            lnk_next.pdx_slow = addr[DDRT_MR_PDX_BIT];
        end
        // The reset chain keeps running so release is seen on ck.
        if (!lnk_reg.rs2) begin
            lnk_next = '0;
            lnk_next.rs1 = reset_n;
            lnk_next.rs2 = lnk_reg.rs1;
            lnk_next.cke_cnt = CKE_MIN;
            lnk_next.dqs_diff = DDRT_DQS_DIFF_RST;
            lnk_next.pdx_slow = DDRT_PDX_SLOW_RST;
        end
    end

    // Memory clock state register.
    always_ff @(posedge ck) begin
        lnk_reg <= lnk_next;
    end

    assign xing.src = {lnk_reg.pdx_slow, lnk_reg.dqs_diff,
                       lnk_reg.rp_tgl, lnk_reg.cke_tgl};

    ddrt_sync #(.WIDTH(XW)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .xing(xing)
    );

    // System side: toggles turn into single pulses, levels are held.
    always_comb begin
        sys_next = sys_reg;
        sys_next.cke_tgl_q = xing.dst[0];
        sys_next.rp_tgl_q = xing.dst[1];
        sys_next.cke_err = xing.dst[0] ^ sys_reg.cke_tgl_q;
        sys_next.rp_err = xing.dst[1] ^ sys_reg.rp_tgl_q;
        sys_next.dqs_diff = xing.dst[2];
        sys_next.pdx_slow = xing.dst[3];
        if (!reset_n) begin
            sys_next = '0;
            sys_next.dqs_diff = DDRT_DQS_DIFF_RST;
            sys_next.pdx_slow = DDRT_PDX_SLOW_RST;
        end
    end

    // System clock state register.
    always_ff @(posedge clk) begin
        sys_reg <= sys_next;
    end

    // Termination drives straight from the ck domain with no crossing,
    // so its latency is counted in ck edges alone.
    assign odt_term = lnk_reg.term;
    assign dqs_diff_mode = sys_reg.dqs_diff;
    assign slow_pd_exit = sys_reg.pdx_slow;
    assign cke_err = sys_reg.cke_err;
    assign rp_err = sys_reg.rp_err;

    // Named steps of a too-early activate.
    sequence s_pre_then_act;
        is_pre ##1 (is_act && lnk_reg.rp_cnt != '0);
    endsequence

    a_odt_on_delay: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        $rose(lnk_reg.odt_sh[0]) |-> ##2 $rose(lnk_reg.term))
        else $error("Termination did not turn on two edges after ODT.");

    a_odt_off_delay: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        $fell(lnk_reg.odt_sh[0]) |-> ##2 $fell(lnk_reg.term))
        else $error("Termination did not turn off on the expected edge.");

    a_cke_short_pulse: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        (cke_change && lnk_reg.cke_cnt < CKE_MIN) |=>
        (lnk_reg.cke_tgl != $past(lnk_reg.cke_tgl)))
        else $error("Short CKE pulse was not flagged.");

    a_rp_early_act: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        (is_act && lnk_reg.rp_cnt != '0) |=>
        (lnk_reg.rp_tgl != $past(lnk_reg.rp_tgl)))
        else $error("Early activate was not flagged.");

    a_rp_quick_pair: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        s_pre_then_act |=> $changed(lnk_reg.rp_tgl))
        else $error("Activate one cycle after precharge not flagged.");

    a_emr_dqs_mode: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        is_mrs_emr |=>
        (lnk_reg.dqs_diff == !$past(addr[DDRT_EMR_DQS_BIT])))
        else $error("Strobe mode does not follow extended mode bit.");

    a_mr_exit_mode: assert property (
        @(posedge ck) disable iff (!ck_rst_n)
        is_mrs_mr |=> (lnk_reg.pdx_slow == $past(addr[DDRT_MR_PDX_BIT])))
        else $error("Exit timing does not follow mode bit.");

    a_err_one_pulse: assert property (
        @(posedge clk) disable iff (!reset_n)
        cke_err |=> !cke_err)
        else $error("CKE error pulse stood longer than one cycle.");

endmodule

// file: ddrt_ctrl_model.sv
// Purpose: Controller model that drives the memory pins of the timing block.
// Assumes: Pins change only just after a rising edge of ck.
// Notes:   Only mode, precharge, activate and deselect cycles are issued.
`timescale 1ns/1ps
module ddrt_ctrl_model
    import ddrt_pkg::*;
(
    input wire logic ck,
    output logic cke,
    output logic odt,
    output logic [3:0] cmd,
    output logic [2:0] ba,
    output logic [DDRT_ADDR_W-1:0] addr
);
    // Idle pins at time zero, with the command lines deselected.
    initial begin
        cke = 1'b1;
        odt = 1'b0;
        cmd = 4'hF;
        ba = 3'h0;
        addr = '0;
    end

    // One command for one edge, then deselect. The address is inverted
    // while idle, so a stale value cannot pass for a held one.
    // No read, write or clock change is ever issued.
    task automatic issue(input logic [3:0] c, input logic [2:0] b,
                         input logic [DDRT_ADDR_W-1:0] a);
        @(posedge ck);
        cmd <= c;
        ba <= b;
        addr <= a;
        @(posedge ck);
        cmd <= 4'hF;
        addr <= ~a;
    endtask

    // Two commands on back-to-back edges, then deselect. This is the
    // only way to reach the tightest spacing that the pins allow.
    task automatic issue_pair(input logic [3:0] c0, input logic [3:0] c1,
                              input logic [2:0] b);
        @(posedge ck);
        cmd <= c0;
        ba <= b;
        @(posedge ck);
        cmd <= c1;
        @(posedge ck);
        cmd <= 4'hF;
    endtask

    // Set a CKE level and keep it for n registering edges.
    task automatic cke_hold(input logic v, input int n);
        @(posedge ck);
        cke <= v;
        repeat (n - 1) @(posedge ck);
    endtask

    // Change the termination request just after an edge.
    task automatic odt_set(input logic v);
        @(posedge ck);
        odt <= v;
    endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the command timing block.
// Assumes: ck runs free at 80 ns with a phase unrelated to clk.
// Notes:   A short clock period gives a precharge window of six cycles.
`timescale 1ns/1ps
module tb;
    import ddrt_pkg::*;
    localparam int TCK_PS = 2500;
    localparam int TRP_PS = 13125;
    // Precharge window in ck cycles, rounded up by hand.
    localparam int TNRP = (TRP_PS + TCK_PS - 1) / TCK_PS;
    logic clk = 1'b0;
    logic ck = 1'b0;
    logic reset_n = 1'b0;
    wire logic cke;
    wire logic odt;
    wire logic [3:0] cmd;
    wire logic [2:0] ba;
    wire logic [DDRT_ADDR_W-1:0] addr;
    wire logic odt_term;
    wire logic dqs_diff_mode;
    wire logic slow_pd_exit;
    wire logic cke_err;
    wire logic rp_err;
    int errors = 0;
    int compares = 0;
    int cke_seen = 0;
    int rp_seen = 0;

    ddrt_ctrl_model ctl (.ck(ck), .cke(cke), .odt(odt), .cmd(cmd),
        .ba(ba), .addr(addr));

    ddrt_timing #(.TCK_AVG_PS(TCK_PS), .TRP_PS(TRP_PS)) uut (.clk(clk),
        .reset_n(reset_n), .ck(ck), .cke(cke), .odt(odt),
        .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
        .ba(ba), .addr(addr), .odt_term(odt_term),
        .dqs_diff_mode(dqs_diff_mode), .slow_pd_exit(slow_pd_exit),
        .cke_err(cke_err), .rp_err(rp_err));

    // System clock at 50 MHz.
    always #10 clk = ~clk;

    // Link clock, offset so its edges never meet those of clk.
    initial begin
        #13;
        forever #40 ck = ~ck;
    end

    // Error pulses last one cycle, so they are counted, not sampled late.
    // An unknown level counts as a pulse, so it cannot pass for quiet.
    always @(posedge clk) begin
        if (cke_err !== 1'b0) cke_seen++;
        if (rp_err !== 1'b0) rp_seen++;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic t_reset();
        check("odt_term", odt_term, 1'b0);
        check("dqs_diff_mode", dqs_diff_mode, DDRT_DQS_DIFF_RST);
        check("slow_pd_exit", slow_pd_exit, DDRT_PDX_SLOW_RST);
        check("cke_err", cke_err, 1'b0);
        check("rp_err", rp_err, 1'b0);
        $display("test reset done");
    endtask

    // The level must hold for one more edge, then follow.
    task automatic t_odt();
        for (int v = 1; v >= 0; v--) begin
            ctl.odt_set(v[0]);
            repeat (DDRT_ODT_DELAY) @(posedge ck);
            #1;
            check("odt_term early", odt_term, !v[0]);
            @(posedge ck);
            #1;
            check("odt_term", odt_term, v[0]);
        end
        $display("test odt done");
    endtask

    task automatic t_mode();
        logic [DDRT_ADDR_W-1:0] a;
        for (int v = 1; v >= 0; v--) begin
            a = '0;
            a[DDRT_EMR_DQS_BIT] = v[0];
            ctl.issue(DDRT_CMD_MRS, DDRT_BA_EMR, a);
            a = '0;
            a[DDRT_MR_PDX_BIT] = v[0];
            ctl.issue(DDRT_CMD_MRS, DDRT_BA_MR, a);
            repeat (8) @(posedge clk);
            check("dqs_diff_mode", dqs_diff_mode, !v[0]);
            check("slow_pd_exit", slow_pd_exit, v[0]);
        end
        $display("test mode done");
    endtask

    // A high pulse of one, two and three registered edges.
    task automatic t_cke();
        for (int n = 1; n <= DDRT_CKE_MIN; n++) begin
            ctl.cke_hold(1'b0, 4);
            cke_seen = 0;
            ctl.cke_hold(1'b1, n);
            ctl.cke_hold(1'b0, 4);
            repeat (8) @(posedge clk);
            check("cke_err count", cke_seen, (n < DDRT_CKE_MIN));
            ctl.cke_hold(1'b1, 4);
        end
        $display("test cke done");
    endtask

    // Activate on the very next edge, one cycle too soon, then on time.
    task automatic t_rp();
        rp_seen = 0;
        ctl.issue_pair(DDRT_CMD_PRE, DDRT_CMD_ACT, 3'h2);
        repeat (2) @(posedge ck);
        repeat (8) @(posedge clk);
        check("rp_err pair", rp_seen, (TNRP > 1));
        for (int k = TNRP - 1; k <= TNRP; k++) begin
            rp_seen = 0;
            ctl.issue(DDRT_CMD_PRE, 3'h2, '0);
            repeat (k - 2) @(posedge ck);
            ctl.issue(DDRT_CMD_ACT, 3'h2, '0);
            repeat (2) @(posedge ck);
            repeat (8) @(posedge clk);
            check("rp_err count", rp_seen, (k < TNRP));
        end
        $display("test precharge done");
    endtask

    // Reset must span three ck edges as well, so it outlasts 8 clk cycles.
    initial begin
        repeat (8) @(posedge clk);
        repeat (3) @(posedge ck);
        @(posedge clk);
        t_reset();
        reset_n <= 1'b1;
        repeat (3) @(posedge ck);
        t_odt();
        t_mode();
        t_cke();
        t_rp();
        report_and_stop();
    end

    // The whole run needs about 7.9 us; over twenty times that means a hang.
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end
endmodule
